// ==== rtl/sba_pkg.sv ====
// shared constants for the secondary bus arbiter control block
package sba_pkg;

	// -------------------------------------------------------------------
	// register map (byte addresses)
	// -------------------------------------------------------------------
	localparam logic [7:0] SBA_ADDR_ARB_PRIO = 8'h40; // arbiter_priority_control
	localparam logic [7:0] SBA_ADDR_EXT_READ = 8'h48; // extended_read_control
	localparam logic [7:0] SBA_ADDR_PREEMPT = 8'h4C; // arbiter_preemption_control

	// -------------------------------------------------------------------
	// field positions
	// -------------------------------------------------------------------
	localparam int SBA_PRIO_LSB = 16; // external requester priority bits 19:16
	localparam int SBA_BPORT_PRIO_BIT = 25; // bridge_port_priority_select
	localparam int SBA_EXT_FLOW_BIT = 0; // memory read flow-through enable
	localparam int SBA_EXT_PARK_BIT = 1; // park on bridge port
	localparam int SBA_EXT_DSPF_BIT = 2; // downstream dynamic prefetch disable
	localparam int SBA_EXT_USPF_BIT = 3; // upstream dynamic prefetch disable
	localparam int SBA_EXT_RBUF_BIT = 4; // read buffer hold-off mode
	localparam int SBA_EXT_WIDTH = 5; // implemented bits 4:0
	localparam int SBA_PRE_LSB = 28; // preemption field bits 31:28

	// -------------------------------------------------------------------
	// reset values
	// -------------------------------------------------------------------
	localparam logic [3:0] SBA_PRIO_RST = 4'h0; // external requesters low
	localparam logic SBA_BPORT_PRIO_RST = 1'b1; // bridge port high
	localparam logic [4:0] SBA_EXT_RST = 5'h00; // all extended bits clear
	localparam logic [3:0] SBA_PRE_RST = 4'h0; // preemption code after reset

	// -------------------------------------------------------------------
	// requesters and preemption timing
	// -------------------------------------------------------------------
	localparam int SBA_NREQ = 5; // four external plus bridge port
	localparam logic [2:0] SBA_BPORT_IDX = 3'h4; // index of the bridge port
	localparam logic [6:0] SBA_PRE_MAX = 7'h40; // longest preemption delay, 64 cycles

	// preemption code to delay in clock cycles after frame assertion
	function automatic logic [6:0] sba_pre_delay(input logic [2:0] code);
		sba_pre_delay = (code == 3'h0) ? 7'h00 : 7'(7'h01 << (code - 3'h1));
	endfunction : sba_pre_delay

	// read buffer sequencing states
	typedef enum logic [1:0] {
		SBA_RB_IDLE = 2'b00,
		SBA_RB_FILL = 2'b01,
		SBA_RB_STREAM = 2'b10
	} sba_rb_e;

endpackage : sba_pkg

// ==== rtl/sba_arbiter.sv ====
// secondary bus arbiter with apb configuration and read buffer control
//
// The implementer's own choice: the APB register port.
`timescale 1ns/1ps
`default_nettype none

module sba_arbiter
	import sba_pkg::*;
(
	input wire logic pclk, // secondary bus clock, 20 MHz
	input wire logic presetn, // asynchronous reset, active low
	input wire logic psel, // apb select
	input wire logic penable, // apb access phase
	input wire logic pwrite, // apb direction
	input wire logic [7:0] paddr, // apb byte address
	input wire logic [31:0] pwdata, // apb write data
	output logic [31:0] prdata, // apb read data
	output logic pready, // apb ready, always high
	output logic pslverr, // apb error on unmapped address
	input wire logic [3:0] req_n, // external bus requests, active low pins
	input wire logic frame_n, // bus frame pin, active low
	input wire logic bport_req, // bridge secondary port request
	output logic [3:0] gnt_n, // external grants, active low
	output logic bport_gnt, // bridge secondary port grant
	input wire logic rd_active, // memory read being returned to a master
	input wire logic rd_buf_empty, // read data buffer empty
	input wire logic rd_line_full, // one cache line buffered
	output logic rd_data_go, // present read data this cycle
	output logic rd_wait, // insert a wait state
	output logic rd_disconnect, // disconnect the requesting master
	output logic flow_through_en, // memory read flow-through enabled
	output logic ds_prefetch_en, // downstream dynamic prefetch enabled
	output logic us_prefetch_en // upstream dynamic prefetch enabled
);

	// -------------------------------------------------------------------
	// pin synchronisers
	// -------------------------------------------------------------------
	logic [3:0] req_meta_reg; // first stage, read only by second
	logic [3:0] req_sync_reg; // synchronised requests, active low
	logic frame_meta_reg; // first stage of frame
	logic frame_sync_reg; // synchronised frame, active low

	// two flip-flops per pin before any logic looks at it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			req_meta_reg <= 4'hF;
			req_sync_reg <= 4'hF;
			frame_meta_reg <= 1'b1;
			frame_sync_reg <= 1'b1;
		end else begin
			req_meta_reg <= req_n;
			req_sync_reg <= req_meta_reg;
			frame_meta_reg <= frame_n;
			frame_sync_reg <= frame_meta_reg;
		end
	end

	// -------------------------------------------------------------------
	// configuration registers
	// -------------------------------------------------------------------
	logic [3:0] prio_reg, prio_next; // external requester priorities
	logic bport_prio_reg, bport_prio_next; // bridge port priority
	logic [4:0] ext_reg, ext_next; // extended read control bits
	logic [3:0] pre_reg, pre_next; // preemption code
	logic [31:0] prdata_reg, prdata_next; // read data captured in setup
	logic wr_en; // write strobe at access phase
	logic addr_hit; // address maps to a register

	assign wr_en = psel && penable && pwrite;
	assign addr_hit = (paddr == SBA_ADDR_ARB_PRIO) || (paddr == SBA_ADDR_EXT_READ) ||
		(paddr == SBA_ADDR_PREEMPT);

	// next register values from apb writes and read mux
	always_comb begin
		prio_next = prio_reg;
		bport_prio_next = bport_prio_reg;
		ext_next = ext_reg;
		pre_next = pre_reg;
		prdata_next = prdata_reg;
		if (wr_en && paddr == SBA_ADDR_ARB_PRIO) begin
			prio_next = pwdata[SBA_PRIO_LSB +: 4];
			bport_prio_next = pwdata[SBA_BPORT_PRIO_BIT];
		end
		if (wr_en && paddr == SBA_ADDR_EXT_READ) begin
			ext_next = pwdata[SBA_EXT_WIDTH-1:0];
		end
		if (wr_en && paddr == SBA_ADDR_PREEMPT) begin
			pre_next = pwdata[SBA_PRE_LSB +: 4];
		end
		// read data captured in the setup cycle
		if (psel && !penable && !pwrite) begin
			prdata_next = 32'h0000_0000;
			case (paddr)
				SBA_ADDR_ARB_PRIO: begin
					prdata_next[SBA_PRIO_LSB +: 4] = prio_reg;
					prdata_next[SBA_BPORT_PRIO_BIT] = bport_prio_reg;
				end
				SBA_ADDR_EXT_READ: prdata_next[SBA_EXT_WIDTH-1:0] = ext_reg;
				SBA_ADDR_PREEMPT: prdata_next[SBA_PRE_LSB +: 4] = pre_reg;
				default: prdata_next = 32'h0000_0000;
			endcase
		end
	end

	// register storage
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prio_reg <= SBA_PRIO_RST;
			bport_prio_reg <= SBA_BPORT_PRIO_RST;
			ext_reg <= SBA_EXT_RST;
			pre_reg <= SBA_PRE_RST;
			prdata_reg <= 32'h0000_0000;
		end else begin
			prio_reg <= prio_next;
			bport_prio_reg <= bport_prio_next;
			ext_reg <= ext_next;
			pre_reg <= pre_next;
			prdata_reg <= prdata_next;
		end
	end

	assign prdata = prdata_reg;
	assign pready = 1'b1;
	assign pslverr = psel && penable && !addr_hit;

	// -------------------------------------------------------------------
	// configuration outputs
	// -------------------------------------------------------------------
	// flow-through and dynamic prefetch enables
	assign flow_through_en = ext_reg[SBA_EXT_FLOW_BIT];
	assign ds_prefetch_en = !ext_reg[SBA_EXT_DSPF_BIT];
	assign us_prefetch_en = !ext_reg[SBA_EXT_USPF_BIT];

	// -------------------------------------------------------------------
	// preemption timer
	// -------------------------------------------------------------------
	logic [6:0] frame_cnt_reg, frame_cnt_next; // cycles since frame asserted
	logic frame_act; // frame asserted on the bus
	logic preempt_ok; // preemption currently allowed

	assign frame_act = !frame_sync_reg;

	// count from frame assertion, saturating at the longest delay
	always_comb begin
		frame_cnt_next = frame_cnt_reg;
		if (!frame_act) begin
			frame_cnt_next = 7'h00;
		end else if (frame_cnt_reg < SBA_PRE_MAX) begin
			frame_cnt_next = frame_cnt_reg + 7'h01;
		end
	end

	// frame counter storage
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			frame_cnt_reg <= 7'h00;
		end else begin
			frame_cnt_reg <= frame_cnt_next;
		end
	end

	assign preempt_ok = !pre_reg[3] && frame_act &&
		(frame_cnt_reg >= sba_pre_delay(pre_reg[2:0]));

	// -------------------------------------------------------------------
	// arbitration
	// -------------------------------------------------------------------
	logic [SBA_NREQ-1:0] req_vec; // pending requests, active high
	logic [SBA_NREQ-1:0] prio_vec; // high priority flags
	logic [SBA_NREQ-1:0] grant_reg, grant_next; // one-hot grant
	logic [2:0] last_reg, last_next; // last granted requester
	logic [2:0] win_idx; // chosen requester
	logic win_found; // any requester chosen
	logic owner_req; // current owner still requesting
	logic other_req; // someone else pending

	assign req_vec = {bport_req, ~req_sync_reg};
	assign prio_vec = {bport_prio_reg, prio_reg};

	// round robin search from the requester after last
	function automatic logic [3:0] sba_pick(input logic [SBA_NREQ-1:0] mask,
		input logic [2:0] last);
		logic [3:0] res;
		logic [2:0] idx;
		res = 4'h0;
		idx = last;
		for (int i = 0; i < SBA_NREQ; i++) begin
			idx = (idx == 3'(SBA_NREQ - 1)) ? 3'h0 : idx + 3'h1;
			if (!res[3] && mask[idx]) begin
				res = {1'b1, idx};
			end
		end
		return res;
	endfunction : sba_pick

	// winner among requesters other than the owner, or the owner when it alone requests
	always_comb begin
		logic [3:0] hi;
		logic [3:0] lo;
		logic [SBA_NREQ-1:0] cand;
		cand = (|(req_vec & ~grant_reg)) ? (req_vec & ~grant_reg) : req_vec;
		hi = sba_pick(cand & prio_vec, last_reg);
		lo = sba_pick(cand & ~prio_vec, last_reg);
		win_found = hi[3] || lo[3];
		win_idx = hi[3] ? hi[2:0] : lo[2:0];
	end

	assign owner_req = |(grant_reg & req_vec);
	assign other_req = |(req_vec & ~grant_reg);

	// grant decisions
	always_comb begin
		grant_next = grant_reg;
		last_next = last_reg;
		if (!owner_req) begin
			if (win_found) begin
				grant_next = SBA_NREQ'(1) << win_idx;
				last_next = win_idx;
			end else if (ext_reg[SBA_EXT_PARK_BIT]) begin
				grant_next = SBA_NREQ'(1) << SBA_BPORT_IDX;
			end else if (|grant_reg) begin
				grant_next = grant_reg;
			end else begin
				grant_next = SBA_NREQ'(1) << last_reg;
			end
		end else if (other_req && preempt_ok && win_found) begin
			grant_next = SBA_NREQ'(1) << win_idx;
			last_next = win_idx;
		end
	end

	// grant storage
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			grant_reg <= '0;
			last_reg <= SBA_BPORT_IDX;
		end else begin
			grant_reg <= grant_next;
			last_reg <= last_next;
		end
	end

	assign gnt_n = ~grant_reg[3:0];
	assign bport_gnt = grant_reg[SBA_BPORT_IDX];

	// -------------------------------------------------------------------
	// read data buffer control
	// -------------------------------------------------------------------
	sba_rb_e rb_state_reg, rb_state_next; // read return sequencing
	logic rb_hold; // hold-off mode selected

	assign rb_hold = ext_reg[SBA_EXT_RBUF_BIT];

	// read return state machine
	always_comb begin
		rb_state_next = rb_state_reg;
		case (rb_state_reg)
			SBA_RB_IDLE: begin
				// idle until a read is returned
				if (rd_active) begin
					rb_state_next = rb_hold ? SBA_RB_FILL : SBA_RB_STREAM;
				end
			end
			SBA_RB_FILL: begin
				if (!rd_active) begin
					rb_state_next = SBA_RB_IDLE;
				end else if (rd_line_full) begin
					rb_state_next = SBA_RB_STREAM;
				end
			end
			SBA_RB_STREAM: begin
				// data streaming
				if (!rd_active) begin
					rb_state_next = SBA_RB_IDLE;
				end
			end
			default: rb_state_next = SBA_RB_IDLE;
		endcase
	end

	// read state storage
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rb_state_reg <= SBA_RB_IDLE;
		end else begin
			rb_state_reg <= rb_state_next;
		end
	end

	// return, wait and disconnect strobes
	always_comb begin
		rd_data_go = 1'b0;
		rd_wait = 1'b0;
		rd_disconnect = 1'b0;
		if (rd_active) begin
			if (!rb_hold) begin
				rd_data_go = !rd_buf_empty;
				rd_wait = rd_buf_empty;
			end else if (rb_state_reg == SBA_RB_STREAM) begin
				rd_data_go = !rd_buf_empty;
				rd_disconnect = rd_buf_empty;
			end else begin
				rd_wait = 1'b1;
			end
		end
	end
endmodule : sba_arbiter
`default_nettype wire

// ==== tb/sba_pci_masters.sv ====
// behavioural secondary bus masters driving request and frame pins
`timescale 1ns/1ps
`default_nettype none

module sba_pci_masters (
	input wire logic pclk, // secondary bus clock
	input wire logic presetn, // reset, active low
	input wire logic [3:0] want, // masters that wish to own the bus
	input wire logic xfer, // granted owner runs a transaction
	input wire logic [3:0] gnt_n, // grants from the arbiter
	output logic [3:0] req_n, // request pins, idle high
	output logic frame_n // frame pin, pulled up when idle
);
	// requests follow the wishes; frame only from a granted owner that still requests
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			req_n <= 4'hF;
			frame_n <= 1'b1;
		end else begin
			req_n <= ~want;
			frame_n <= !(xfer && |(~gnt_n & want));
		end
	end
endmodule : sba_pci_masters

`default_nettype wire

// ==== tb/sba_arbiter_monitor.sv ====
// port checker for the secondary bus arbiter
`timescale 1ns/1ps
`default_nettype none

module sba_arbiter_monitor
	import sba_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [3:0] req_n,
	input wire logic frame_n,
	input wire logic bport_req,
	input wire logic [3:0] gnt_n,
	input wire logic bport_gnt,
	input wire logic rd_active,
	input wire logic rd_buf_empty,
	input wire logic rd_line_full,
	input wire logic rd_data_go,
	input wire logic rd_wait,
	input wire logic flow_through_en,
	input wire logic ds_prefetch_en,
	input wire logic us_prefetch_en
);
	logic park_h; // mirrored park bit
	logic mode_h; // mirrored read buffer mode
	logic [3:0] pre_h; // mirrored preemption code
	logic [6:0] fcnt; // run of frame low samples
	logic [6:0] dly_h; // decoded preemption delay
	wire logic wr = psel && penable && pwrite && pready;

	// mirror control bits from completed writes, count frame low
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			park_h <= 1'b0;
			mode_h <= 1'b0;
			pre_h <= SBA_PRE_RST;
			fcnt <= 7'h00;
		end else begin
			if (wr && paddr == SBA_ADDR_EXT_READ) begin
				park_h <= pwdata[1];
				mode_h <= pwdata[4];
			end
			if (wr && paddr == SBA_ADDR_PREEMPT) begin
				pre_h <= pwdata[31:28];
			end
			fcnt <= frame_n ? 7'h00 : ((fcnt == 7'h7F) ? fcnt : fcnt + 7'h01);
		end
	end
	assign dly_h = (pre_h[2:0] == 3'h0) ? 7'h00 : 7'(7'h01 << (pre_h[2:0] - 3'h1));

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	property p_slverr;
		psel && penable |-> pslverr == !(paddr inside {8'h40, 8'h48, 8'h4C});
	endproperty
	a_slverr: assert property (p_slverr) else $error("bad error response");
	property p_ctl_out;
		wr && paddr == SBA_ADDR_EXT_READ |=> flow_through_en == $past(pwdata[0])
			&& ds_prefetch_en == !$past(pwdata[2]) && us_prefetch_en == !$past(pwdata[3]);
	endproperty
	a_ctl_out: assert property (p_ctl_out) else $error("control output mismatch");
	property p_mode0;
		rd_active && !mode_h |-> rd_data_go == !rd_buf_empty && rd_wait == rd_buf_empty;
	endproperty
	a_mode0: assert property (p_mode0) else $error("immediate mode wrong");
	property p_mode1;
		$rose(rd_active) && mode_h && !rd_line_full |-> rd_wait && !rd_data_go;
	endproperty
	a_mode1: assert property (p_mode1) else $error("hold-off mode gave data");
	property p_one_grant;
		$onehot0({~gnt_n, bport_gnt});
	endproperty
	a_one_grant: assert property (p_one_grant) else $error("two grants");
	property p_grant_cause;
		|(~gnt_n & $past(gnt_n)) |-> (~gnt_n & $past(gnt_n) & $past(req_n, 3)) == 4'h0;
	endproperty
	a_grant_cause: assert property (p_grant_cause) else $error("grant without request");
	property p_park;
		(park_h && req_n == 4'hF && !bport_req)[*5] |=> bport_gnt && gnt_n == 4'hF;
	endproperty
	a_park: assert property (p_park) else $error("not parked on bridge");
	property p_preempt;
		(req_n[0] == 1'b0)[*4] ##0 $rose(gnt_n[0]) |-> !pre_h[3] && $past(fcnt) >= dly_h;
	endproperty
	a_preempt: assert property (p_preempt) else $error("early preemption");
endmodule : sba_arbiter_monitor

bind sba_arbiter sba_arbiter_monitor i_sba_arbiter_monitor (.*);

`default_nettype wire

// ==== tb/tb_top.sv ====
// self-checking bench for the secondary bus arbiter
`timescale 1ns/1ps
`default_nettype none

module tb_top
	import sba_pkg::*;
;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, r, d;
	logic pready, pslverr, bport_gnt, rd_data_go, rd_wait, rd_disconnect, e, frame_n;
	logic flow_through_en, ds_prefetch_en, us_prefetch_en, xfer = 1'b0, bport_req = 1'b0;
	logic rd_active = 1'b0, rd_buf_empty = 1'b0, rd_line_full = 1'b0;
	logic [3:0] req_n, gnt_n, want = 4'h0, wv, code;
	int err_count = 0, num_checks = 0, cyc = 0, last = 4, n, w, dl;
	logic [31:0] mm [3]; // register model
	localparam logic [31:0] MSK [3] = '{32'h020F_0000, 32'h0000_001F, 32'hF000_0000};
	localparam logic [7:0] ADR [3] = '{SBA_ADDR_ARB_PRIO, SBA_ADDR_EXT_READ, SBA_ADDR_PREEMPT};

	sba_arbiter i_sba_arbiter (.*);
	sba_pci_masters i_sba_pci_masters (.*);

	// clock and hang guard
	always #25 pclk = ~pclk;
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 30000) begin
			err_count++;
			tally_and_finish();
		end
	end

	task automatic tally_and_finish();
		$display("checks %0d errors %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : tally_and_finish

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			err_count++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// one apb transfer, waits for pready
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] dv);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= dv;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	// grant pattern {gnt_n, bport_gnt} for a winner index
	function automatic logic [31:0] gp(input int k);
		return (k == 4) ? 32'h1F : 32'({~(4'h1 << k), 1'b0});
	endfunction : gp

	// priority first, then round robin after the last winner
	function automatic int win(input logic [4:0] q, input logic [4:0] hp, input int lst);
		for (int lv = 1; lv >= 0; lv--)
			for (int k = 1; k <= 5; k++)
				if (q[(lst + k) % 5] && hp[(lst + k) % 5] == lv) return (lst + k) % 5;
		return lst;
	endfunction : win

	initial begin
		void'($urandom(7));
		mm = '{32'h0200_0000, 32'h0, 32'h0};
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		for (int i = 0; i < 3; i++) begin
			apb(1'b0, ADR[i], 32'h0);
			chk(r, mm[i]);
		end
		chk(32'({flow_through_en, ds_prefetch_en, us_prefetch_en}), 32'h3);
		$display("test reset done");
		for (int p = 0; p < 3; p++)
			for (int i = 0; i < 3; i++) begin
				d = (p == 0) ? 32'hFFFF_FFFF : $urandom;
				apb(1'b1, ADR[i], d);
				mm[i] = d & MSK[i];
				apb(1'b0, ADR[i], 32'h0);
				chk(r, mm[i]);
				chk(32'(e), 32'h0);
				chk(32'({flow_through_en, ds_prefetch_en, us_prefetch_en}),
					32'({mm[1][0], !mm[1][2], !mm[1][3]}));
			end
		apb(1'b1, 8'h44, 32'hFFFF_FFFF);
		apb(1'b0, 8'h44, 32'h0);
		chk(r, 32'h0);
		chk(32'(e), 32'h1);
		$display("test registers done");
		apb(1'b1, SBA_ADDR_EXT_READ, 32'h0);
		for (int t = 0; t < 8; t++) begin
			d = $urandom;
			apb(1'b1, SBA_ADDR_ARB_PRIO, d);
			mm[0] = d & MSK[0];
			@(posedge pclk);
			wv = 4'(1 + $urandom % 15);
			want <= wv;
			repeat (8) @(posedge pclk);
			#1;
			w = win({1'b0, wv}, {mm[0][25], mm[0][19:16]}, last);
			// an owner that still asks keeps the bus
			if (last < 4 && wv[last]) begin
				w = last;
			end
			chk(32'({gnt_n, bport_gnt}), gp(w));
			last = w;
			@(posedge pclk);
			want <= 4'h0;
			repeat (8) @(posedge pclk);
			#1;
			chk(32'({gnt_n, bport_gnt}), gp(w));
		end
		apb(1'b1, SBA_ADDR_EXT_READ, 32'h2);
		repeat (8) @(posedge pclk);
		#1;
		chk(32'({gnt_n, bport_gnt}), gp(4));
		$display("test arbitration done");
		apb(1'b1, SBA_ADDR_EXT_READ, 32'h0);
		@(posedge pclk);
		rd_active <= 1'b1;
		repeat (8) begin
			@(posedge pclk);
			rd_buf_empty <= 1'($urandom);
			#1;
			chk(32'({rd_data_go, rd_wait}), 32'({!rd_buf_empty, rd_buf_empty}));
		end
		@(posedge pclk);
		rd_active <= 1'b0;
		rd_buf_empty <= 1'b0;
		apb(1'b1, SBA_ADDR_EXT_READ, 32'h10);
		@(posedge pclk);
		rd_active <= 1'b1;
		repeat (4) @(posedge pclk);
		#1;
		chk(32'({rd_data_go, rd_wait}), 32'h1);
		@(posedge pclk);
		rd_line_full <= 1'b1;
		n = 0;
		while (rd_data_go !== 1'b1 && n < 5) begin
			@(posedge pclk);
			#1;
			n++;
		end
		chk(32'(rd_data_go), 32'h1);
		@(posedge pclk);
		rd_buf_empty <= 1'b1;
		#1;
		chk(32'(rd_disconnect), 32'h1);
		@(posedge pclk);
		rd_active <= 1'b0;
		$display("test read buffer done");
		apb(1'b1, SBA_ADDR_ARB_PRIO, 32'h0);
		for (int c = 0; c < 9; c++) begin
			code = (c == 8) ? 4'(8 + $urandom % 8) : 4'(c);
			apb(1'b1, SBA_ADDR_PREEMPT, 32'h8000_0000);
			@(posedge pclk);
			want <= 4'h1;
			repeat (8) @(posedge pclk);
			apb(1'b1, SBA_ADDR_PREEMPT, {code, 28'h0});
			@(posedge pclk);
			want <= 4'h3;
			xfer <= 1'b1;
			n = 0;
			while (gnt_n[0] === 1'b0 && n < 90) begin
				@(posedge pclk);
				#1;
				n++;
			end
			dl = code[3] ? 90 : ((code == 4'h0) ? 0 : 1 << (int'(code) - 1));
			chk(32'(n >= dl && n <= dl + 8), 32'h1);
			chk(32'({gnt_n, bport_gnt}), gp(code[3] ? 0 : 1));
			@(posedge pclk);
			xfer <= 1'b0;
			want <= 4'h0;
			repeat (6) @(posedge pclk);
		end
		$display("test preemption done");
		tally_and_finish();
	end
endmodule : tb_top

`default_nettype wire
